/* verilog/crap_pkg.sv */
`default_nettype none
package crap_pkg;
  // ==========================================================================
  // Token and field encodings.
  // ==========================================================================
  localparam logic [7:0] TOK_WRITE = 8'hc0;
  localparam logic [7:0] TOK_READ  = 8'hc1;
  localparam logic [7:0] TOK_END   = 8'h01;
  localparam logic [7:0] TOK_ACK   = 8'h03;
  localparam logic [7:0] TOK_NACK  = 8'h04;
  localparam logic [7:0] NOREPLY_LOW = 8'hff;
  localparam logic [7:0] PS_RES_TYPE = 8'h0b;
  localparam int unsigned PS_SHIFT    = 8;
  // Suffix bits that route a channel-end to the tile and node banks.
  localparam logic [15:0] TILE_CFG_SUFFIX = 16'hc20c;
  localparam logic [15:0] NODE_CFG_SUFFIX = 16'hc30c;
  // ==========================================================================
  // Register bank.
  // ==========================================================================
  localparam int unsigned NUM_REGS = 8;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ==========================================================================
  // Reset timing at 40 MHz.
  // ==========================================================================
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned RST_MIN_US   = 5;
  localparam int unsigned INIT_MAX_US  = 150;
  localparam int unsigned RST_MIN_CYC  = RST_MIN_US * CLK_MHZ;
  localparam int unsigned INIT_MAX_CYC = INIT_MAX_US * CLK_MHZ;
  localparam int unsigned BOOT_DLY_CYC = 16;
  // Count of bytes per field, minus one.
  localparam logic [2:0] ID_LAST   = 3'h2;
  localparam logic [2:0] REG_LAST  = 3'h1;
  localparam logic [2:0] DATA_LAST = 3'h3;

  // Processor-status resource identifier for a register number.
  function automatic logic [31:0] ps_resource(input logic [15:0] regnum);
    ps_resource = ({16'h0000, regnum} << PS_SHIFT) | {24'h000000, PS_RES_TYPE};
  endfunction
endpackage
`default_nettype wire

/* verilog/crap_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Token link: each direction carries a byte with a control flag, valid/ready.
interface crap_link_if;
  logic       req_valid;
  logic       req_ready;
  logic       req_ctrl;
  logic [7:0] req_data;
  logic       rsp_valid;
  logic       rsp_ready;
  logic       rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  modport dev (input req_valid, req_ctrl, req_data, rsp_ready,
               output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest);
  modport req (output req_valid, req_ctrl, req_data, rsp_ready,
               input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest);
endinterface
`default_nettype wire

/* verilog/crap_device.sv */
`timescale 1ns/1ps
`default_nettype none
module crap_device (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Link.
  crap_link_if.dev         link,
  // User side.
  output logic             booted_o,
  output logic [31:0]      reg0_o,
  output logic [31:0]      ps_res_o
);
  // ==========================================================================
  // State.
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000, ST_IDLE = 3'b001, ST_ID = 3'b011, ST_REG = 3'b010,
    ST_DATA = 3'b110, ST_END = 3'b111, ST_RSP = 3'b101, ST_SKIP = 3'b100
  } crap_dev_st_t;

  // Depth of the register bank; must exist before the state struct uses it.
  localparam int unsigned NUM_REGS_W = crap_pkg::NUM_REGS;

  typedef struct packed {
    crap_dev_st_t st;
    logic [12:0]  boot_cnt;
    logic         booted;
    logic         is_read;
    logic         bad;
    logic [2:0]   bcnt;
    logic [23:0]  reply_id;
    logic [15:0]  regnum;
    logic [31:0]  wdata;
    logic [31:0]  rdata;
    logic [2:0]   rsp_idx;
    logic         rsp_valid;
    logic         rsp_ctrl;
    logic [7:0]   rsp_data;
    logic         req_ready;
    logic [31:0]  ps_res;
    logic [NUM_REGS_W-1:0][31:0] regs;
  } crap_dev_t;

  crap_dev_t s_r;
  crap_dev_t s_nxt;
  logic      take;
  logic      sent;
  logic      ok;

  assign take = link.req_valid && s_r.req_ready;
  assign sent = s_r.rsp_valid && link.rsp_ready;
  assign ok   = !s_r.bad && (s_r.regnum < 16'(crap_pkg::NUM_REGS));

  // Byte of the response sequence; index 0 is the status token.
  function automatic logic [8:0] rsp_byte(input logic [2:0] idx,
                                          input logic good, input logic rd,
                                          input logic [31:0] d);
    if (idx == 3'h0) begin
      rsp_byte = {1'b1, good ? crap_pkg::TOK_ACK : crap_pkg::TOK_NACK};
    end else if (good && rd && idx < 3'h5) begin
      rsp_byte = {1'b0, d[8'(31 - 8 * (idx - 3'h1)) -: 8]};
    end else begin
      rsp_byte = {1'b1, crap_pkg::TOK_END};
    end
  endfunction

  // ==========================================================================
  // Next state. Unaligned framing is skipped to the closing token; a surplus byte where that token is due is answered at once.
  // ==========================================================================
  always_comb begin
    logic [8:0] b;
    logic [2:0] last;
    b = 9'h000;
    last = 3'h0;
    s_nxt = s_r;
    if (sent) begin
      s_nxt.rsp_valid = 1'b0;
    end
    unique case (s_r.st)
      ST_BOOT: begin
        // Boot starts a fixed delay after release, well inside the limit.
        s_nxt.boot_cnt = s_r.boot_cnt + 13'h0001;
        if (s_r.boot_cnt == 13'(crap_pkg::BOOT_DLY_CYC)) begin
          s_nxt.booted = 1'b1;
          s_nxt.req_ready = 1'b1;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          s_nxt.bcnt = 3'h0;
          s_nxt.bad = 1'b0;
          if (link.req_ctrl && link.req_data == crap_pkg::TOK_WRITE) begin
            s_nxt.is_read = 1'b0;
            s_nxt.st = ST_ID;
          end else if (link.req_ctrl &&
                       link.req_data == crap_pkg::TOK_READ) begin
            s_nxt.is_read = 1'b1;
            s_nxt.st = ST_ID;
          end else if (!(link.req_ctrl &&
                         link.req_data == crap_pkg::TOK_END)) begin
            s_nxt.st = ST_SKIP;
          end
        end
      end
      ST_ID, ST_REG, ST_DATA: begin
        last = (s_r.st == ST_ID) ? crap_pkg::ID_LAST :
               (s_r.st == ST_REG) ? crap_pkg::REG_LAST : crap_pkg::DATA_LAST;
        if (take) begin
          if (link.req_ctrl) begin
            s_nxt.bad = 1'b1;
            s_nxt.st = (link.req_data == crap_pkg::TOK_END) ? ST_RSP : ST_SKIP;
            s_nxt.rsp_idx = 3'h0;
            s_nxt.req_ready = (link.req_data != crap_pkg::TOK_END);
          end else begin
            s_nxt.bcnt = s_r.bcnt + 3'h1;
            // Most significant byte first: shift in at the bottom.
            if (s_r.st == ST_ID) begin
              s_nxt.reply_id = {s_r.reply_id[15:0], link.req_data};
            end else if (s_r.st == ST_REG) begin
              s_nxt.regnum = {s_r.regnum[7:0], link.req_data};
            end else begin
              s_nxt.wdata = {s_r.wdata[23:0], link.req_data};
            end
            if (s_r.bcnt == last) begin
              s_nxt.bcnt = 3'h0;
              s_nxt.st = (s_r.st == ST_ID) ? ST_REG :
                         (s_r.st == ST_REG && !s_r.is_read) ? ST_DATA : ST_END;
            end
          end
        end
      end
      ST_END: begin
        if (take) begin
          s_nxt.bad = !(link.req_ctrl && link.req_data == crap_pkg::TOK_END);
          s_nxt.rsp_idx = 3'h0;
          s_nxt.req_ready = 1'b0;
          s_nxt.st = ST_RSP;
          if (!s_nxt.bad && s_r.regnum < 16'(crap_pkg::NUM_REGS)) begin
            if (s_r.is_read) begin
              s_nxt.rdata = s_r.regs[s_r.regnum[2:0]];
            end else begin
              s_nxt.regs[s_r.regnum[2:0]] = s_r.wdata;
            end
          end
          // Silent write: performed, no reply sent.
          if (!s_r.is_read && s_r.reply_id[7:0] == crap_pkg::NOREPLY_LOW
              && link.req_ctrl && link.req_data == crap_pkg::TOK_END) begin
            s_nxt.st = ST_IDLE;
            s_nxt.req_ready = 1'b1;
          end
        end
      end
      ST_RSP: begin
        if (!s_r.rsp_valid || sent) begin
          if (s_r.rsp_idx != 3'h7) begin
            b = rsp_byte(s_r.rsp_idx, ok, s_r.is_read, s_r.rdata);
            s_nxt.rsp_valid = 1'b1;
            s_nxt.rsp_ctrl = b[8];
            s_nxt.rsp_data = b[7:0];
            s_nxt.rsp_idx = (b[8] && b[7:0] == crap_pkg::TOK_END) ?
                            3'h7 : s_r.rsp_idx + 3'h1;
          end else begin
            s_nxt.st = ST_IDLE;
            s_nxt.req_ready = 1'b1;
          end
        end
      end
      ST_SKIP: begin
        if (take && link.req_ctrl && link.req_data == crap_pkg::TOK_END) begin
          s_nxt.bad = 1'b1;
          s_nxt.is_read = 1'b0;
          s_nxt.rsp_idx = 3'h0;
          s_nxt.req_ready = 1'b0;
          s_nxt.st = ST_RSP;
        end
      end
    endcase
    s_nxt.ps_res = crap_pkg::ps_resource(s_nxt.regnum);
  end

  // Register the whole state.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs straight from flip-flops.
  // ==========================================================================
  assign link.req_ready = s_r.req_ready;
  assign link.rsp_valid = s_r.rsp_valid;
  assign link.rsp_ctrl  = s_r.rsp_ctrl;
  assign link.rsp_data  = s_r.rsp_data;
  assign link.rsp_dest  = s_r.reply_id;
  assign booted_o       = s_r.booted;
  assign reg0_o         = s_r.regs[0];
  assign ps_res_o       = s_r.ps_res;
endmodule
`default_nettype wire

/* verilog/crap_requester.sv */
`timescale 1ns/1ps
`default_nettype none
// Requester end: serialises one command and collects the reply.
module crap_requester (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Link.
  crap_link_if.req         link,
  // Command port.
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_read_i,
  input  wire logic [23:0] cmd_reply_id_i,
  input  wire logic [15:0] cmd_reg_i,
  input  wire logic [31:0] cmd_wdata_i,
  output logic             cmd_ready_o,
  // Result.
  output logic             done_o,
  output logic             ok_o,
  output logic [31:0]      rdata_o
);
  typedef enum logic [1:0] {
    RQ_IDLE = 2'b00, RQ_SEND = 2'b01, RQ_WAIT = 2'b11
  } crap_req_st_t;

  typedef struct packed {
    crap_req_st_t st;
    logic [3:0]   idx;
    logic [3:0]   last;
    logic [79:0]  frame;
    logic         silent;
    logic         valid;
    logic         ctrl;
    logic [7:0]   data;
    logic         ready;
    logic         done;
    logic         ok;
    logic [31:0]  rdata;
  } crap_req_t;

  crap_req_t s_r;
  crap_req_t s_nxt;

  // Send, then collect reply bytes until closing token.
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      RQ_IDLE: begin
        s_nxt.ready = 1'b1;
        if (cmd_valid_i && s_r.ready) begin
          // Fields go most significant byte first.
          s_nxt.frame = {cmd_reply_id_i, cmd_reg_i, cmd_wdata_i, 8'h00};
          s_nxt.last = cmd_read_i ? 4'h6 : 4'ha;
          s_nxt.silent = !cmd_read_i &&
                         cmd_reply_id_i[7:0] == crap_pkg::NOREPLY_LOW;
          s_nxt.valid = 1'b1;
          s_nxt.ctrl = 1'b1;
          s_nxt.data = cmd_read_i ? crap_pkg::TOK_READ : crap_pkg::TOK_WRITE;
          s_nxt.idx = 4'h1;
          s_nxt.ready = 1'b0;
          s_nxt.st = RQ_SEND;
        end
      end
      RQ_SEND: begin
        if (link.req_ready) begin
          if (s_r.idx > s_r.last) begin
            s_nxt.valid = 1'b0;
            s_nxt.ok = 1'b0;
            s_nxt.st = s_r.silent ? RQ_IDLE : RQ_WAIT;
            s_nxt.done = s_r.silent;
          end else if (s_r.idx == s_r.last) begin
            s_nxt.ctrl = 1'b1;
            s_nxt.data = crap_pkg::TOK_END;
            s_nxt.idx = s_r.idx + 4'h1;
          end else begin
            s_nxt.ctrl = 1'b0;
            s_nxt.data = s_r.frame[79:72];
            s_nxt.frame = {s_r.frame[71:0], 8'h00};
            s_nxt.idx = s_r.idx + 4'h1;
          end
        end
      end
      RQ_WAIT: begin
        if (link.rsp_valid) begin
          if (link.rsp_ctrl && link.rsp_data == crap_pkg::TOK_ACK) begin
            s_nxt.ok = 1'b1;
          end else if (!link.rsp_ctrl) begin
            s_nxt.rdata = {s_r.rdata[23:0], link.rsp_data};
          end else if (link.rsp_data == crap_pkg::TOK_END) begin
            s_nxt.done = 1'b1;
            s_nxt.st = RQ_IDLE;
          end
        end
      end
      default: s_nxt.st = RQ_IDLE;
    endcase
  end

  // Register the whole state.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.req_valid = s_r.valid;
  assign link.req_ctrl  = s_r.ctrl;
  assign link.req_data  = s_r.data;
  assign link.rsp_ready = (s_r.st == RQ_WAIT);
  assign cmd_ready_o    = s_r.ready;
  assign done_o         = s_r.done;
  assign ok_o           = s_r.ok;
  assign rdata_o        = s_r.rdata;
endmodule
`default_nettype wire

/* sim/crap_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Link watcher
module crap_link_monitor (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Link signals.
  input  wire logic        req_valid,
  input  wire logic        req_ready,
  input  wire logic        req_ctrl,
  input  wire logic [7:0]  req_data,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ready,
  input  wire logic        rsp_ctrl,
  input  wire logic [7:0]  rsp_data,
  input  wire logic [23:0] rsp_dest
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic [3:0]  idx_r;
  logic [23:0] id_r;
  logic        rd_r;
  logic        busy_r;
  logic        nack_r;
  logic [2:0]  cnt_r;
  wire logic req_take = req_valid && req_ready;
  wire logic rsp_take = rsp_valid && rsp_ready;
  wire logic head = req_take && req_ctrl && !idx_r[3] && idx_r == 4'h0;
  wire logic req_end = req_take && req_ctrl && req_data == crap_pkg::TOK_END;
  wire logic rsp_end = rsp_take && rsp_ctrl && rsp_data == crap_pkg::TOK_END;
  // Track request fields; the id is shifted in so MSB-first order shows.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_r <= 4'h0;
      id_r <= 24'h000000;
      rd_r <= 1'b0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      cnt_r <= 3'h0;
    end else begin
      if (req_end) idx_r <= 4'h0;
      else if (head) idx_r <= 4'h1;
      else if (req_take && idx_r != 4'h0 && idx_r != 4'hf) begin
        idx_r <= idx_r + 4'h1;
      end
      if (head) rd_r <= req_data[0];
      if (req_take && idx_r >= 4'h1 && idx_r <= 4'h3) begin
        id_r <= {id_r[15:0], req_data};
      end
      if (rsp_take) busy_r <= !rsp_end;
      if (rsp_take) cnt_r <= busy_r ? cnt_r + 3'h1 : 3'h0;
      if (rsp_take && !busy_r) nack_r <= rsp_data == crap_pkg::TOK_NACK;
    end
  end
  sequence close_s;
    req_end;
  endsequence
  sequence silent_s;
    close_s ##0 (!rd_r && id_r[7:0] == crap_pkg::NOREPLY_LOW);
  endsequence
  req_hold_a: assert property (
    req_valid && !req_ready |=>
      req_valid && $stable(req_data) && $stable(req_ctrl))
    else $error("request byte changed before taken");
  rsp_hold_a: assert property (
    rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_data) && $stable(rsp_ctrl))
    else $error("reply byte changed before taken");
  no_overlap_a: assert property (rsp_valid |-> !req_ready)
    else $error("request accepted while replying");
  reply_head_a: assert property (rsp_take && !busy_r |-> rsp_ctrl &&
    (rsp_data == crap_pkg::TOK_ACK || rsp_data == crap_pkg::TOK_NACK))
    else $error("reply does not open with status token");
  reply_data_a: assert property (
    rsp_take && busy_r && !rsp_end |-> !rsp_ctrl && !nack_r && rd_r)
    else $error("data byte in wrong reply");
  reply_len_a: assert property (rsp_end && busy_r |->
    cnt_r == ((nack_r || !rd_r) ? 3'h0 : 3'h4))
    else $error("reply has wrong length");
  reply_time_a: assert property (
    close_s ##0 !(!rd_r && id_r[7:0] == crap_pkg::NOREPLY_LOW) |->
      ##[1:2] rsp_valid)
    else $error("reply late");
  silent_a: assert property (silent_s |=> !rsp_valid [*4])
    else $error("reply sent for silent write");
  reply_dest_a: assert property (rsp_valid |-> rsp_dest == id_r)
    else $error("reply routed to wrong id");
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bench
module tb;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cmd_valid_i = 1'b0;
  logic        cmd_read_i = 1'b0;
  logic [15:0] cmd_reg_i = 16'h0000;
  logic [31:0] cmd_wdata_i = 32'h00000000;
  logic [23:0] cmd_reply_id_i = 24'h012345;
  logic        cmd_ready_o, done_o, ok_o, booted_o, booted2;
  logic [31:0] rdata_o, reg0_o, reg0_2, ps_res_o;
  int          miscompares = 0;
  int          comparisons = 0;
  crap_link_if link ();
  crap_link_if link2 ();
  // Clock at 40 MHz.
  always #12.5 mclk_i = ~mclk_i;
  crap_requester crap_requester_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .link(link.req), .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i),
    .cmd_reply_id_i(cmd_reply_id_i), .cmd_reg_i(cmd_reg_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .ok_o(ok_o), .rdata_o(rdata_o));
  crap_device crap_device_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .link(link.dev), .booted_o(booted_o), .reg0_o(reg0_o), .ps_res_o(ps_res_o));
  // Second device faces the bench, which can break the framing on purpose.
  crap_device crap_device_i2 (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .link(link2.dev), .booted_o(booted2), .reg0_o(reg0_2), .ps_res_o());
  crap_link_monitor crap_link_monitor_i (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_ctrl(link.req_ctrl),
    .req_data(link.req_data), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_ctrl(link.rsp_ctrl),
    .rsp_data(link.rsp_data), .rsp_dest(link.rsp_dest));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command through the requester; results are read at the done edge.
  task automatic cmd(input logic rd, input logic [15:0] rg,
                     input logic [31:0] wd, input logic eok,
                     input logic [31:0] ed);
    int n;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b1;
    cmd_read_i <= rd;
    cmd_reg_i <= rg;
    cmd_wdata_i <= wd;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 99);
    cmd_valid_i <= 1'b0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (done_o !== 1'b1 && n < 300);
    // A hang must not pass as an expected failure status.
    chk("done", 32'h1, {31'h0, done_o});
    chk("status", {31'h0, eok}, {31'h0, ok_o});
    if (rd && eok) chk("read data", ed, rdata_o);
  endtask
  // Raw byte to the second device, held until it is taken.
  task automatic put(input logic c, input logic [7:0] b);
    int n;
    @(posedge mclk_i);
    link2.req_valid <= 1'b1;
    link2.req_ctrl <= c;
    link2.req_data <= b;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (!link2.req_ready && n < 99);
    link2.req_valid <= 1'b0;
  endtask
  task automatic put_f(input logic [31:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--) put(1'b0, v[8*i +: 8]);
  endtask
  // Reply bytes are looked at mid-cycle, away from the launching edge.
  task automatic get(input logic c, input logic [7:0] b);
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (link2.rsp_valid !== 1'b1 && n < 99);
    // A stale byte left on the link must not stand in for a missing one.
    chk("reply valid", 32'h1, {31'h0, link2.rsp_valid});
    chk("reply ctrl", {31'h0, c}, {31'h0, link2.rsp_ctrl});
    chk("reply byte", {24'h0, b}, {24'h0, link2.rsp_data});
    @(posedge mclk_i);
  endtask
  task automatic t_boot();
    int n;
    n = 0;
    chk("ready in boot", 32'h0, {31'h0, link.req_ready});
    do begin @(posedge mclk_i); n++; end
      while (booted_o !== 1'b1 && n < crap_pkg::INIT_MAX_CYC);
    chk("booted", 32'h1, {31'h0, booted_o});
    chk("booted two", 32'h1, {31'h0, booted2});
  endtask
  task automatic t_regs();
    chk("tile dest", 32'h0001c20c, {16'h1, crap_pkg::TILE_CFG_SUFFIX});
    chk("node dest", 32'h0002c30c, {16'h2, crap_pkg::NODE_CFG_SUFFIX});
    cmd(1'b0, 16'h0000, 32'hc3a5_0f1e, 1'b1, 32'h0);
    chk("reg0", 32'hc3a5_0f1e, reg0_o);
    cmd(1'b1, 16'h0000, 32'h0, 1'b1, 32'hc3a5_0f1e);
    for (int r = 1; r < 8; r++) begin
      cmd(1'b0, 16'(r), 32'h1234_5601 * r, 1'b1, 32'h0);
    end
    chk("status id", ({16'h0, 16'h0007} << 8) | 32'h0b, ps_res_o);
    for (int r = 1; r < 8; r++) begin
      cmd(1'b1, 16'(r), 32'h0, 1'b1, 32'h1234_5601 * r);
    end
  endtask
  task automatic t_bad_reg();
    cmd(1'b0, 16'h0008, 32'hdead_0001, 1'b0, 32'h0);
    cmd(1'b1, 16'hffff, 32'h0, 1'b0, 32'h0);
    chk("reg0 kept", 32'hc3a5_0f1e, reg0_o);
  endtask
  // Silent write through the requester; the read back must still answer.
  task automatic t_quiet();
    cmd_reply_id_i <= 24'h0123ff;
    cmd(1'b0, 16'h0003, 32'h5a5a_a5a5, 1'b0, 32'h0);
    cmd_reply_id_i <= 24'h012345;
    cmd(1'b1, 16'h0003, 32'h0, 1'b1, 32'h5a5a_a5a5);
  endtask
  task automatic t_silent();
    int bad;
    bad = 0;
    put(1'b1, crap_pkg::TOK_WRITE);
    put_f(32'h00ab12ff, 3);
    put_f(32'h00000000, 2);
    put_f(32'h89abcdef, 4);
    put(1'b1, crap_pkg::TOK_END);
    repeat (8) begin @(negedge mclk_i); bad += int'(link2.rsp_valid === 1'b1); end
    chk("silent", 32'h0, 32'(bad));
    chk("silent reg0", 32'h89abcdef, reg0_2);
  endtask
  task automatic t_wire();
    put(1'b1, crap_pkg::TOK_READ);
    put_f(32'h005a5a01, 3);
    put_f(32'h00000000, 2);
    put(1'b1, crap_pkg::TOK_END);
    get(1'b1, crap_pkg::TOK_ACK);
    chk("dest", 32'h005a5a01, {8'h0, link2.rsp_dest});
    get(1'b0, 8'h89);
    get(1'b0, 8'hab);
    get(1'b0, 8'hcd);
    get(1'b0, 8'hef);
    get(1'b1, crap_pkg::TOK_END);
  endtask
  task automatic t_frame();
    put(1'b1, crap_pkg::TOK_WRITE);
    put_f(32'h00ab1201, 3);
    put(1'b1, crap_pkg::TOK_END);
    get(1'b1, crap_pkg::TOK_NACK);
    get(1'b1, crap_pkg::TOK_END);
    // A stray control token in place of a header is skipped to the close.
    put(1'b1, 8'h07);
    put(1'b0, 8'h00);
    put(1'b1, crap_pkg::TOK_END);
    get(1'b1, crap_pkg::TOK_NACK);
    get(1'b1, crap_pkg::TOK_END);
    chk("frame reg0", 32'h89abcdef, reg0_2);
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    link2.req_valid = 1'b0;
    link2.req_ctrl = 1'b0;
    link2.req_data = 8'h00;
    link2.rsp_ready = 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_boot();
    t_regs();
    t_bad_reg();
    t_quiet();
    t_silent();
    t_wire();
    t_frame();
    results();
  end
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #(25 * 20000);
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
